// ### hw/mrb_pkg.sv
package mrb_pkg;

	// ***************************************************
	// Widths
	// ***************************************************
	localparam int ADDR_W = 13;
	localparam int DQ_W = 16;
	localparam int MEM_DEPTH = 64;

	// ***************************************************
	// Mode register field positions
	// ***************************************************
	localparam int BLM_BL_LSB = 0;
	localparam int BLM_CL_HI = 2;
	localparam int BLM_BT = 3;
	localparam int BLM_CL_LSB = 4;
	localparam int BLM_DLL_RST = 8;
	localparam int BLM_WR_LSB = 9;
	localparam int BLM_PPD = 12;
	localparam int DTM_DLL_DIS = 0;
	localparam int DTM_AL_LSB = 3;
	localparam int DTM_QOFF = 12;
	localparam int BC_SEL_BIT = 12;

	// ***************************************************
	// Encodings and reset values
	// ***************************************************
	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;
	localparam logic [1:0] AL_CL1 = 2'h1;
	localparam logic [1:0] AL_CL2 = 2'h2;
	localparam logic [2:0] BA_BLM = 3'h0;
	localparam logic [2:0] BA_DTM = 3'h1;
	localparam logic [12:0] MR_RST = 13'h0000;
	localparam logic [2:0] LAST_BEAT = 3'h7;
	localparam logic [2:0] FIX4_LAST_BEAT = 3'h3;

	// ***************************************************
	// Timing, counted in link clock cycles
	// ***************************************************
	localparam logic [4:0] CL_BASE = 5'h04;
	localparam logic [4:0] CWL_CK = 5'h05;
	localparam logic [4:0] TRP_CK = 5'h0B;
	localparam logic [9:0] DLLK_CK = 10'h200;

	// ***************************************************
	// Types
	// ***************************************************
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] ba;
		logic [ADDR_W-1:0] addr;
	} mrb_cmd_t;

	typedef enum logic [2:0] {DLL_OFF, DLL_LOCK, DLL_ON, DLL_FROZEN, DLL_SREF} mrb_dll_t;
	typedef enum logic [1:0] {P_ACT, P_SREF, P_PPD} mrb_pwr_t;
	typedef enum logic [1:0] {B_IDLE, B_WAIT, B_XFER} mrb_burst_t;

	// ***************************************************
	// Field decoders
	// ***************************************************
	function automatic logic [4:0] mrb_cl(input logic [12:0] m);
		mrb_cl = CL_BASE + {2'h0, m[BLM_CL_LSB+:3]} + (m[BLM_CL_HI] ? 5'h08 : 5'h00);
	endfunction

	function automatic logic [4:0] mrb_wr(input logic [12:0] m);
		case (m[BLM_WR_LSB+:3])
			3'h1: mrb_wr = 5'h05;
			3'h2: mrb_wr = 5'h06;
			3'h3: mrb_wr = 5'h07;
			3'h4: mrb_wr = 5'h08;
			3'h5: mrb_wr = 5'h0A;
			3'h6: mrb_wr = 5'h0C;
			3'h7: mrb_wr = 5'h0E;
			default: mrb_wr = 5'h10;
		endcase
	endfunction

	function automatic logic [4:0] mrb_al(input logic [12:0] m1, input logic [4:0] cl);
		case (m1[DTM_AL_LSB+:2])
			AL_CL1: mrb_al = cl - 5'h01;
			AL_CL2: mrb_al = cl - 5'h02;
			default: mrb_al = 5'h00;
		endcase
	endfunction

endpackage

// ### hw/mrb_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of pins
module mrb_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// First stage is read only by the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule

// ### hw/mrb_burst_order.sv
`timescale 1ns/1ps
// Column offset for one beat of a burst
module mrb_burst_order (
	input wire logic [2:0] start,
	input wire logic interleave,
	input wire logic is_write,
	input wire logic bc4,
	input wire logic [2:0] beat,
	output logic [2:0] col
);
	always_comb begin
		if (is_write) begin
			// Low start bits ignored; chop picks a half by bit 2
			col = bc4 ? {start[2], beat[1:0]} : beat; // RULE7
		end else if (interleave) begin
			col = start ^ beat; // RULE5
		end else begin
			// Wrap within a half, then swap halves
			col = {start[2] ^ beat[2], start[1:0] + beat[1:0]}; // RULE4
		end
	end
endmodule

// ### hw/mrb_top.sv
`timescale 1ns/1ps
//Contract
//RULE1: Burst mode bit A3 picks sequential or interleaved column order.
//RULE2: Burst mode A1:A0 picks fixed chop 4, fixed 8, or per-command choice.
//RULE3: In per-command mode, A12 at read/write picks chop 4 or 8.
//RULE4: Sequential 8 read wraps low two bits, then the other half.
//RULE5: Interleaved read beat i uses start column XOR i.
//RULE6: Chop 4 read floats data and strobe for last four beat slots.
//RULE7: Writes ignore low start bits; chop 4 write uses A2 for half.
//RULE8: Fixed chop 4 starts internal write two clocks earlier.
//RULE9: Per-command chop write keeps the 8-beat internal write start.
//RULE10: DLL reset bit clears itself once the reset is done.
//RULE11: Controller waits DLL lock before reads; DLL enable then reset.
//RULE12: WR field A11:A9 plus precharge time sets auto-precharge delay.
//RULE13: Controller programs WR at least write recovery over clock, rounded up.
//RULE14: A12 low freezes DLL in precharge power-down, slow exit.
//RULE15: Mode set with bank 001 loads MR1 from address pins.
//RULE16: Enabled DLL turns off in self-refresh, on again at exit.
//RULE17: Controller keeps clock enable high during DLL lock time.
//RULE18: DLL-off mode needs termination off by pin or termination mode bits.
//RULE19: Controller clears MR2 dynamic termination before DLL-off mode.
//RULE20: Write leveling with bit12 low limits nominal termination values.
//RULE21: Nominal termination during writes limited to three values.
//RULE22: Commands held for additive latency; RL=AL+CL, WL=AL+CWL.
//RULE23: Mode set with all bank bits low loads the burst mode register.
//RULE24: Burst length code 00 fixed 8, 01 on the fly, 10 chop 4.
//RULE25: Additive code 00 zero, 01 CL-1, 10 CL-2, 11 reserved.
module mrb_top
	import mrb_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ck_pin,
	input wire logic reset_pin_n,
	input wire mrb_cmd_t cmd_pins,
	input wire logic [DQ_W-1:0] dq_in,
	output logic [DQ_W-1:0] dq_out,
	output logic dq_oe,
	output logic dqs_out,
	output logic dqs_oe,
	output logic dll_running,
	output logic dll_locked,
	output logic ppd_slow_exit,
	output logic wr_ref_pulse,
	output logic [4:0] read_lat,
	output logic [4:0] write_lat,
	output logic [4:0] tdal_ck
);

	// ***************************************************
	// Pin synchronisation and link clock edges
	// ***************************************************
	localparam int SW = 2 + $bits(mrb_cmd_t) + DQ_W;

	logic [SW-1:0] sync_q;
	logic ck_s;
	logic rst_pin_n_s;
	mrb_cmd_t cmd_s;
	logic [DQ_W-1:0] dq_s;
	logic ck_prev_ff;
	logic ck_rise;
	logic ck_fall;
	logic ck_edge;
	logic rst_all;

	// Pins all share one delay so command and clock stay aligned
	mrb_sync #(.W(SW)) u_sync (.clk(clk), .sys_rst(sys_rst),
		.d({ck_pin, reset_pin_n, cmd_pins, dq_in}), .q(sync_q));
	assign {ck_s, rst_pin_n_s, cmd_s, dq_s} = sync_q;
	// Edge finder on the synchronised link clock
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ck_prev_ff <= 1'b0;
		end else begin
			ck_prev_ff <= ck_s;
		end
	end

	assign ck_rise = ck_s & ~ck_prev_ff;
	assign ck_fall = ~ck_s & ck_prev_ff;
	assign ck_edge = ck_rise | ck_fall;
	// The reset pin clears all state past the synchroniser and edge finder except the data memory, as the system reset does
	assign rst_all = sys_rst | ~rst_pin_n_s;

	// ***************************************************
	// Command decode
	// ***************************************************
	logic cke_prev_ff;
	logic sel;
	logic is_mrs;
	logic is_ref;
	logic is_rd;
	logic is_wr;
	logic cke_on;

	// Clock enable must have been high on the previous edge too
	always_ff @(posedge clk) begin
		if (rst_all) begin
			cke_prev_ff <= 1'b0;
		end else if (ck_rise) begin
			cke_prev_ff <= cmd_s.cke;
		end
	end

	assign cke_on = cke_prev_ff & cmd_s.cke;
	assign sel = ck_rise & ~cmd_s.cs_n;
	assign is_mrs = sel & ~cmd_s.ras_n & ~cmd_s.cas_n & ~cmd_s.we_n;
	assign is_ref = sel & ~cmd_s.ras_n & ~cmd_s.cas_n & cmd_s.we_n;
	assign is_rd = sel & cmd_s.ras_n & ~cmd_s.cas_n & cmd_s.we_n & cke_on;
	assign is_wr = sel & cmd_s.ras_n & ~cmd_s.cas_n & ~cmd_s.we_n & cke_on;

	// ***************************************************
	// Mode registers
	// ***************************************************
	logic [12:0] burst_latency_mode_reg_ff;
	logic [12:0] dll_termination_mode_reg_ff;
	logic dll_rst_done;
	// A new mode set beats the self-clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst_all) begin
			burst_latency_mode_reg_ff <= MR_RST;
			dll_termination_mode_reg_ff <= MR_RST;
		end else if (is_mrs && cke_on && cmd_s.ba == BA_BLM) begin
			burst_latency_mode_reg_ff <= cmd_s.addr; // RULE23
		end else if (is_mrs && cke_on && cmd_s.ba == BA_DTM) begin
			dll_termination_mode_reg_ff <= cmd_s.addr; // RULE15
		end else if (dll_rst_done) begin
			burst_latency_mode_reg_ff[BLM_DLL_RST] <= 1'b0; // RULE10
		end
	end
	logic [4:0] cl_v;
	logic [4:0] al_v;
	logic [1:0] bl_code;
	assign cl_v = mrb_cl(burst_latency_mode_reg_ff);
	assign al_v = mrb_al(dll_termination_mode_reg_ff, cl_v); // RULE25
	assign bl_code = burst_latency_mode_reg_ff[BLM_BL_LSB+:2];

	// Latency figures presented for the controller side
	always_ff @(posedge clk) begin
		if (rst_all) begin
			read_lat <= 5'h00;
			write_lat <= 5'h00;
			tdal_ck <= 5'h00;
		end else begin
			read_lat <= al_v + cl_v; // RULE22
			write_lat <= al_v + CWL_CK; // RULE22
			tdal_ck <= mrb_wr(burst_latency_mode_reg_ff) + TRP_CK; // RULE12
		end
	end

	// ***************************************************
	// Power state and DLL
	// ***************************************************
	mrb_pwr_t pwr_ff;
	mrb_dll_t dll_ff;
	logic [9:0] lock_cnt_ff;
	logic dll_en;
	logic sref_in;
	logic sref_out;
	logic pd_in;
	logic pd_out;
	logic burst_busy;
	assign dll_en = ~dll_termination_mode_reg_ff[DTM_DLL_DIS];
	assign sref_in = is_ref & cke_prev_ff & ~cmd_s.cke & (pwr_ff == P_ACT);
	assign sref_out = ck_rise & cmd_s.cke & (pwr_ff == P_SREF);
	assign pd_in = ck_rise & cke_prev_ff & ~cmd_s.cke & ~is_ref & ~burst_busy
		& (pwr_ff == P_ACT);
	assign pd_out = ck_rise & cmd_s.cke & (pwr_ff == P_PPD);
	assign dll_rst_done = (dll_ff == DLL_LOCK) & ck_rise & (lock_cnt_ff == 10'h001);
	// Power state follows clock enable
	always_ff @(posedge clk) begin
		if (rst_all) begin
			pwr_ff <= P_ACT;
		end else begin
			case (pwr_ff)
				P_ACT: begin
					if (sref_in) begin
						pwr_ff <= P_SREF;
					end else if (pd_in) begin
						pwr_ff <= P_PPD;
					end
				end
				P_SREF: begin
					if (sref_out) begin
						pwr_ff <= P_ACT;
					end
				end
				P_PPD: begin
					if (pd_out) begin
						pwr_ff <= P_ACT;
					end
				end
				default: pwr_ff <= P_ACT;
			endcase
		end
	end
	// DLL stays off after reset until a reset command arrives
	always_ff @(posedge clk) begin
		if (rst_all) begin
			dll_ff <= DLL_OFF;
			lock_cnt_ff <= 10'h000;
		end else if (!dll_en) begin
			dll_ff <= DLL_OFF;
		end else if (is_mrs && cke_on && cmd_s.ba == BA_BLM && cmd_s.addr[BLM_DLL_RST]) begin
			dll_ff <= DLL_LOCK;
			lock_cnt_ff <= DLLK_CK;
		end else begin
			case (dll_ff)
				DLL_LOCK: begin
					if (sref_in) begin
						dll_ff <= DLL_SREF; // RULE16
					end else if (dll_rst_done) begin
						dll_ff <= DLL_ON;
					end else if (ck_rise) begin
						lock_cnt_ff <= lock_cnt_ff - 10'h001;
					end
				end
				DLL_ON: begin
					if (sref_in) begin
						dll_ff <= DLL_SREF; // RULE16
					end else if (pd_in && !burst_latency_mode_reg_ff[BLM_PPD]) begin
						dll_ff <= DLL_FROZEN; // RULE14
					end
				end
				DLL_SREF: begin
					if (sref_out) begin
						dll_ff <= DLL_ON; // RULE16
					end
				end
				DLL_FROZEN: begin
					if (pd_out) begin
						dll_ff <= DLL_ON; // RULE14
					end
				end
				default: dll_ff <= DLL_OFF;
			endcase
		end
	end
	// Status levels for the DLL and the power-down exit choice
	always_ff @(posedge clk) begin
		if (rst_all) begin
			dll_running <= 1'b0;
			dll_locked <= 1'b0;
			ppd_slow_exit <= 1'b0;
		end else begin
			dll_running <= (dll_ff == DLL_LOCK) || (dll_ff == DLL_ON);
			dll_locked <= dll_ff == DLL_ON;
			ppd_slow_exit <= dll_ff == DLL_FROZEN; // RULE14
		end
	end

	// ***************************************************
	// Burst engine
	// ***************************************************
	mrb_burst_t bst_ff;
	logic [4:0] lat_cnt_ff;
	logic [2:0] beat_ff;
	logic [5:0] col_ff;
	logic rd_ff;
	logic bc4_ff;
	logic fix4_ff;
	logic il_ff;
	logic take;
	logic cmd_bc4;
	logic go;
	logic [2:0] nbeat;
	logic [2:0] ocol;
	logic [2:0] end_beat;
	logic [DQ_W-1:0] mem [0:MEM_DEPTH-1];

	// Only one burst in flight; others are dropped
	assign burst_busy = bst_ff != B_IDLE;
	assign take = (is_rd | is_wr) & ~burst_busy & (pwr_ff == P_ACT);
	// Chop choice from mode, or from A12 per command
	always_comb begin
		case (bl_code)
			BL_FIX4: cmd_bc4 = 1'b1; // RULE24
			BL_OTF: cmd_bc4 = ~cmd_s.addr[BC_SEL_BIT]; // RULE3
			default: cmd_bc4 = 1'b0; // RULE2
		endcase
	end

	assign go = (bst_ff == B_WAIT && ck_rise && lat_cnt_ff == 5'h01)
		|| (bst_ff == B_XFER && ck_edge && beat_ff != LAST_BEAT);
	assign nbeat = (bst_ff == B_WAIT) ? 3'h0 : beat_ff + 3'h1;
	assign end_beat = fix4_ff ? FIX4_LAST_BEAT : LAST_BEAT; // RULE8 RULE9

	mrb_burst_order u_order (.start(col_ff[2:0]), .interleave(il_ff), .is_write(~rd_ff),
		.bc4(bc4_ff), .beat(nbeat), .col(ocol));
	// Command held for additive latency plus CAS or write latency
	always_ff @(posedge clk) begin
		if (rst_all) begin
			bst_ff <= B_IDLE;
			lat_cnt_ff <= 5'h00;
			beat_ff <= 3'h0;
			col_ff <= 6'h00;
			rd_ff <= 1'b0;
			bc4_ff <= 1'b0;
			fix4_ff <= 1'b0;
			il_ff <= 1'b0;
		end else begin
			case (bst_ff)
				B_IDLE: begin
					if (take) begin
						bst_ff <= B_WAIT;
						lat_cnt_ff <= is_rd ? al_v + cl_v : al_v + CWL_CK; // RULE22
						col_ff <= cmd_s.addr[5:0];
						rd_ff <= is_rd;
						bc4_ff <= cmd_bc4;
						fix4_ff <= bl_code == BL_FIX4;
						il_ff <= burst_latency_mode_reg_ff[BLM_BT]; // RULE1
					end
				end
				B_WAIT: begin
					if (go) begin
						bst_ff <= B_XFER;
						beat_ff <= 3'h0;
					end else if (ck_rise) begin
						lat_cnt_ff <= lat_cnt_ff - 5'h01;
					end
				end
				B_XFER: begin
					if (go) begin
						beat_ff <= nbeat;
					end else if (ck_edge) begin
						bst_ff <= B_IDLE;
					end
				end
				default: bst_ff <= B_IDLE;
			endcase
		end
	end
	// Write data lands on both link clock edges; chop drops the tail
	always_ff @(posedge clk) begin
		if (go && !rd_ff && !(bc4_ff && nbeat[2])) begin
			mem[{col_ff[5:3], ocol}] <= dq_s; // RULE7
		end
	end
	// Read drivers; the output-off bit keeps every driver released
	always_ff @(posedge clk) begin
		if (rst_all) begin
			dq_out <= '0;
			dq_oe <= 1'b0;
			dqs_out <= 1'b0;
			dqs_oe <= 1'b0;
		end else if (go && rd_ff) begin
			dq_out <= mem[{col_ff[5:3], ocol}];
			dq_oe <= !(bc4_ff && nbeat[2]) && !dll_termination_mode_reg_ff[DTM_QOFF]; // RULE6
			dqs_oe <= !(bc4_ff && nbeat[2]) && !dll_termination_mode_reg_ff[DTM_QOFF]; // RULE6
			dqs_out <= ~nbeat[0];
		end else if (bst_ff != B_XFER || ck_edge) begin
			dq_oe <= 1'b0;
			dqs_oe <= 1'b0;
			dqs_out <= 1'b0;
		end
	end
	// Internal write start marks the write recovery reference point
	always_ff @(posedge clk) begin
		if (rst_all) begin
			wr_ref_pulse <= 1'b0;
		end else begin
			wr_ref_pulse <= bst_ff == B_XFER && ck_edge && !rd_ff && beat_ff == end_beat; // RULE8
		end
	end

endmodule

// ### tb/mrb_top_assertions.sv
`timescale 1ns/1ps
module mrb_top_assertions
	import mrb_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reset_pin_n,
	input wire logic dq_oe,
	input wire logic dqs_out,
	input wire logic dqs_oe,
	input wire logic dll_running,
	input wire logic dll_locked,
	input wire logic ppd_slow_exit,
	input wire logic wr_ref_pulse,
	input wire logic [4:0] write_lat,
	input wire logic [4:0] tdal_ck
);
	logic [7:0] run_ff;
	logic [12:0] lock_ff;
	logic [3:0] age_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ****************
	// Helper counters
	// ****************
	// Length of the present drive window
	always_ff @(posedge clk) begin
		run_ff <= dq_oe ? run_ff + 8'h01 : 8'h00;
	end
	// Time spent locking, so an early lock shows up
	always_ff @(posedge clk) begin
		lock_ff <= (dll_running && !dll_locked) ? lock_ff + 13'h0001 : 13'h0000;
	end
	// Latency outputs lag any reset by a few cycles, so wait before judging them
	always_ff @(posedge clk) begin
		if (sys_rst || !reset_pin_n) begin
			age_ff <= 4'h0;
		end else if (age_ff != 4'hF) begin
			age_ff <= age_ff + 4'h1;
		end
	end
	// ****************
	// Properties
	// ****************
	sequence lead;
		$rose(dqs_oe);
	endsequence
	sequence beat_flip;
		dqs_out [*3] ##[1:3] !dqs_out;
	endsequence
	strobe_start_a: assert property (lead |-> beat_flip)
		else $error("strobe did not start high and toggle");
	oe_pair_a: assert property (dq_oe == dqs_oe)
		else $error("data and strobe enables differ");
	burst_len_a: assert property ($fell(dq_oe) |-> run_ff inside {[8'h0F:8'h11], [8'h1F:8'h21]})
		else $error("drive window length wrong");
	pulse_one_a: assert property (wr_ref_pulse |=> !wr_ref_pulse)
		else $error("write reference pulse too long");
	dll_order_a: assert property (dll_locked |-> dll_running)
		else $error("locked without running");
	lock_time_a: assert property ($rose(dll_locked) && $past(dll_running) |-> lock_ff >= 13'h0FA0)
		else $error("lock finished early");
	ppd_frozen_a: assert property (ppd_slow_exit |-> !dll_locked)
		else $error("delay loop running while frozen");
	lat_sane_a: assert property (age_ff == 4'hF |-> write_lat >= CWL_CK && tdal_ck inside
		{5'h10, 5'h11, 5'h12, 5'h13, 5'h15, 5'h17, 5'h19, 5'h1B})
		else $error("latency outputs out of range");
endmodule

bind mrb_top mrb_top_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
	.dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dll_running(dll_running),
	.dll_locked(dll_locked), .ppd_slow_exit(ppd_slow_exit), .wr_ref_pulse(wr_ref_pulse),
	.write_lat(write_lat), .tdal_ck(tdal_ck));

// ### tb/mrb_ctl_model.sv
`timescale 1ns/1ps
module mrb_ctl_model
	import mrb_pkg::*;
(
	input wire logic clk,
	input wire logic dq_oe,
	input wire logic dqs_out,
	input wire logic [DQ_W-1:0] dq_out,
	input wire logic wr_ref_pulse,
	output logic ck_pin,
	output mrb_cmd_t cmd_pins,
	output logic [DQ_W-1:0] dq_in
);
	int cyc;
	int t_cmd;
	int pulse_d;
	logic [17:0] beat_q [8];
	// Link clock runs free; offset so its edges never meet clk edges
	initial begin
		ck_pin = 1'b0;
		cmd_pins = {1'b0, 4'hF, 3'h0, 13'h0000};
		dq_in = 16'h0000;
		#3;
		forever #40 ck_pin = ~ck_pin;
	end
	// Distance from command edge to write reference pulse
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wr_ref_pulse) begin
			pulse_d <= cyc - t_cmd;
		end
	end
	// Command set up half a link cycle ahead, deselected after its edge
	task automatic issue(input logic k, input logic [3:0] c, input logic [2:0] b,
		input logic [12:0] a);
		@(negedge ck_pin);
		@(posedge clk);
		cmd_pins <= {k, c, b, a};
		@(posedge ck_pin);
		t_cmd = cyc;
		@(negedge ck_pin);
		@(posedge clk);
		cmd_pins.cs_n <= 1'b1;
	endtask
	// Termination bits always cleared; the second dynamic register is never written
	task automatic mrs(input logic [2:0] b, input logic [12:0] a);
		issue(1'b1, 4'h0, b, b == BA_DTM ? a & ~13'h0244 : a);
		repeat (4) @(posedge ck_pin);
	endtask
	// Beats sampled late in each slot, after the synced edge has landed
	task automatic rd(input logic [12:0] a, input int lat);
		issue(1'b1, 4'h5, 3'h0, a);
		repeat (lat) @(posedge ck_pin);
		for (int k = 0; k < 8; k++) begin
			@(ck_pin);
			repeat (2) @(posedge clk);
			beat_q[k] = {dq_oe, dqs_out, dq_out};
		end
	endtask
	// Data changes just before its edge; afterwards the bus shows junk
	task automatic wr(input logic [12:0] a, input int lat, input logic [15:0] d);
		issue(1'b1, 4'h4, 3'h0, a);
		repeat (lat - 1) @(posedge ck_pin);
		@(negedge ck_pin);
		for (int k = 0; k < 8; k++) begin
			repeat (4) @(posedge clk);
			dq_in <= d + 16'(k);
			@(ck_pin);
		end
		repeat (4) @(posedge clk);
		dq_in <= ~dq_in;
		repeat (8) @(posedge clk);
	endtask
	// Clock enable change, then settle
	task automatic cke(input logic v);
		@(negedge ck_pin);
		@(posedge clk);
		cmd_pins.cke <= v;
		repeat (4) @(posedge ck_pin);
	endtask
endmodule

// ### tb/mrb_top_tb.sv
`timescale 1ns/1ps
module mrb_top_tb
	import mrb_pkg::*;
;
	localparam logic [4:0] WR_CK [8] = '{5'h10, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E};
	localparam logic [4:0] AL_V [4] = '{5'h00, 5'h03, 5'h02, 5'h00};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reset_pin_n = 1'b0;
	logic ck_pin;
	mrb_cmd_t cmd_pins;
	logic [DQ_W-1:0] dq_in;
	logic [DQ_W-1:0] dq_out;
	logic dq_oe, dqs_out, dqs_oe, dll_running, dll_locked, ppd_slow_exit, wr_ref_pulse;
	logic [4:0] read_lat, write_lat, tdal_ck;
	logic [15:0] mem [64];
	int failures = 0;
	int total_checks = 0;
	int d8;
	always #5 clk = ~clk;
	mrb_top DUT (.clk(clk), .sys_rst(sys_rst), .ck_pin(ck_pin), .reset_pin_n(reset_pin_n),
		.cmd_pins(cmd_pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
		.dqs_oe(dqs_oe), .dll_running(dll_running), .dll_locked(dll_locked),
		.ppd_slow_exit(ppd_slow_exit), .wr_ref_pulse(wr_ref_pulse), .read_lat(read_lat),
		.write_lat(write_lat), .tdal_ck(tdal_ck));
	mrb_ctl_model CTL (.clk(clk), .dq_oe(dq_oe), .dqs_out(dqs_out), .dq_out(dq_out),
		.wr_ref_pulse(wr_ref_pulse), .ck_pin(ck_pin), .cmd_pins(cmd_pins), .dq_in(dq_in));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic latchk(input logic [4:0] r, input logic [4:0] w, input logic [4:0] t);
		chk("read_lat", 18'(r), 18'(read_lat));
		chk("write_lat", 18'(w), 18'(write_lat));
		chk("tdal_ck", 18'(t), 18'(tdal_ck));
	endtask
	// Shadow copy follows the column placement a write must use
	task automatic wrm(input logic [12:0] a, input logic bc, input logic [15:0] d);
		CTL.wr(a, 5, d);
		for (int k = 0; k < (bc ? 4 : 8); k++) begin
			mem[bc ? {a[5:2], k[1:0]} : {a[5:3], k[2:0]}] = d + 16'(k);
		end
	endtask
	task automatic rdm(input logic [12:0] a, input logic il, input logic bc);
		logic [2:0] o;
		CTL.rd(a, 4);
		for (int i = 0; i < 8; i++) begin
			o = il ? a[2:0] ^ i[2:0] : {a[2] ^ i[2], a[1:0] + i[1:0]};
			if (bc && i > 3) begin
				chk("beat_float", 18'h00000, 18'(CTL.beat_q[i][17]));
			end else begin
				chk("beat", {1'b1, ~i[0], mem[{a[5:3], o}]}, CTL.beat_q[i]);
			end
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Whole sequence needs under 100 us; twice that means a hang
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		reset_pin_n <= 1'b1;
		repeat (12) @(posedge clk);
		latchk(5'h04, 5'h05, 5'h1B);
		CTL.cke(1'b1);
		for (int al = 0; al < 4; al++) begin
			CTL.mrs(BA_DTM, 13'(al << DTM_AL_LSB));
			latchk(5'h04 + AL_V[al], 5'h05 + AL_V[al], 5'h1B);
		end
		for (int w = 0; w < 8; w++) begin
			CTL.mrs(BA_BLM, 13'((w << BLM_WR_LSB) | (w << BLM_CL_LSB)));
			latchk(5'h04 + 5'(w), 5'h05, WR_CK[w] + TRP_CK);
		end
		CTL.mrs(BA_BLM, 13'h0100);
		chk("dll_running", 18'h00001, 18'(dll_running));
		chk("dll_locked", 18'h00000, 18'(dll_locked));
		repeat (520) @(posedge ck_pin);
		chk("dll_locked", 18'h00001, 18'(dll_locked));
		wrm(13'h000D, 1'b0, 16'hA000);
		d8 = CTL.pulse_d;
		for (int t = 0; t < 6; t++) begin
			CTL.mrs(BA_BLM, 13'((t % 2) << BLM_BT));
			rdm(13'(8 + (3 * t + 1) % 8), 1'(t % 2), 1'b0);
		end
		wrm(13'h0010, 1'b0, 16'hC000);
		CTL.mrs(BA_BLM, {11'h000, BL_FIX4});
		wrm(13'h0015, 1'b1, 16'hB000);
		chk("pulse_lead", 18'h00010, 18'(d8 - CTL.pulse_d));
		rdm(13'h0016, 1'b0, 1'b1);
		CTL.mrs(BA_BLM, 13'h0000);
		rdm(13'h0010, 1'b0, 1'b0);
		CTL.mrs(BA_BLM, {11'h000, BL_OTF});
		wrm(13'h1018, 1'b0, 16'hD000);
		wrm(13'h0018, 1'b1, 16'hE000);
		chk("otf_pulse", 18'(d8), 18'(CTL.pulse_d));
		rdm(13'h101B, 1'b0, 1'b0);
		rdm(13'h0019, 1'b0, 1'b1);
		// Slow then fast power-down exit choice
		for (int f = 0; f < 2; f++) begin
			CTL.mrs(BA_BLM, 13'(f << BLM_PPD));
			CTL.cke(1'b0);
			chk("slow_exit", 18'(f == 0), 18'(ppd_slow_exit));
			chk("dll_locked", 18'(f), 18'(dll_locked));
			CTL.cke(1'b1);
		end
		CTL.issue(1'b0, 4'h1, 3'h0, 13'h0000);
		repeat (4) @(posedge ck_pin);
		chk("dll_running", 18'h00000, 18'(dll_running));
		CTL.cke(1'b1);
		chk("dll_locked", 18'h00001, 18'(dll_locked));
		CTL.mrs(BA_DTM, 13'h0008);
		reset_pin_n <= 1'b0;
		repeat (8) @(posedge clk);
		reset_pin_n <= 1'b1;
		repeat (12) @(posedge clk);
		latchk(5'h04, 5'h05, 5'h1B);
		end_of_test();
	end
endmodule
